/* rtl/fdc_host_pkg.sv */
package fdc_host_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [11:0] IDX_TAPE_INFO     = 12'h3F3;
  localparam logic [11:0] IDX_RATE_STATUS   = 12'h3F4;
  localparam logic [11:0] IDX_DATA_PORT     = 12'h3F5;
  localparam logic [11:0] IDX_CONFIG_RATE   = 12'h3F7;
  localparam logic [11:0] IDX_MODE_CONFIG   = 12'h3F8;
  localparam logic [11:0] IDX_DRIVE_KIND    = 12'h3F9;
  localparam logic [11:0] IDX_BOOT_POLARITY = 12'h3FA;
  localparam logic [11:0] IDX_BLOCK_STATUS  = 12'h3FB;
  localparam logic [11:0] IDX_PRECOMP_TRACK = 12'h3FC;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RATE_LSB       = 0;
  localparam int PRECOMP_LSB    = 2;
  localparam int LOW_POWER_BIT  = 6;
  localparam int SOFT_RESET_BIT = 7;
  localparam int POL_HIGH_BIT   = 3;
  localparam int POL_LOW_BIT    = 2;
  localparam int ENHANCED_BIT   = 0;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [1:0] RATE_RESET        = 2'h2;
  localparam logic [2:0] PRECOMP_RESET     = 3'h0;
  localparam logic [1:0] RATE_1M           = 2'h3;
  localparam logic [2:0] PRECOMP_DEFAULT   = 3'h0;
  localparam logic [2:0] PRECOMP_OFF       = 3'h7;
  localparam logic [2:0] STEPS_DEFAULT_1M  = 3'h1;
  localparam logic [2:0] STEPS_DEFAULT_LOW = 3'h3;
  localparam logic [2:0] STEPS_NONE        = 3'h0;
  localparam logic [7:0] TRACK_RESET       = 8'h00;
  localparam logic [7:0] FLOAT_NORMAL      = 8'hFC;

  // ****************************************
  // Data buffer geometry
  // ****************************************
  localparam int         BUF_DEPTH = 16;
  localparam int         BUF_AW    = 4;
  localparam logic [4:0] BUF_FULL  = 5'h10;

  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_RD_WAIT = 2'b01,
    BUS_RD_DONE = 2'b11,
    BUS_WRITE   = 2'b10
  } bus_state_type;

endpackage

/* rtl/fdc_byte_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module fdc_byte_buffer
  import fdc_host_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  // Control
  input  wire logic       flush,
  input  wire logic       single_byte,
  // Fill side
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  // Drain side
  input  wire logic       pop,
  output logic      [7:0] pop_data,
  // State
  output logic      [4:0] count,
  output logic            full,
  output logic            empty
);
  import fdc_host_pkg::*;

  typedef struct packed {
    logic [BUF_DEPTH-1:0][7:0] mem;
    logic [BUF_AW-1:0]         head;
    logic [BUF_AW-1:0]         tail;
    logic [4:0]                cnt;
  } buf_state_type;

  buf_state_type s_r;
  buf_state_type s_nxt;
  logic          do_push;
  logic          do_pop;

  // With the buffer off it behaves as a one-byte holding register
  assign full     = single_byte ? (s_r.cnt != 5'h00) : (s_r.cnt == BUF_FULL);
  assign empty    = (s_r.cnt == 5'h00);
  assign count    = s_r.cnt;
  assign pop_data = s_r.mem[s_r.head];
  assign do_push  = push && !full;
  assign do_pop   = pop && !empty;

  always_comb begin
    s_nxt = s_r;
    if (flush) begin
      s_nxt.head = '0;
      s_nxt.tail = '0;
      s_nxt.cnt  = 5'h00;
    end else begin
      if (do_push) begin
        s_nxt.mem[s_r.tail] = push_data;
        s_nxt.tail          = s_r.tail + 1'b1;
      end
      if (do_pop) begin
        s_nxt.head = s_r.head + 1'b1;
      end
      if (do_push && !do_pop) begin
        s_nxt.cnt = s_r.cnt + 5'h01;
      end else if (do_pop && !do_push) begin
        s_nxt.cnt = s_r.cnt - 5'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

endmodule // fdc_byte_buffer
`default_nettype wire

/* rtl/floppy_host_register_interface.sv */
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module floppy_host_register_interface
  import fdc_host_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic      [7:0]  rdata_float,
  // Drive-side inputs
  input  wire logic        media_sense_pin_low,
  input  wire logic        media_sense_pin_high,
  input  wire logic [1:0]  last_drive_select,
  // Command engine status
  input  wire logic [3:0]  drive_seek_active,
  input  wire logic        command_busy,
  input  wire logic        exec_phase,
  input  wire logic        polled_mode,
  input  wire logic        engine_request,
  input  wire logic        engine_direction,
  input  wire logic        fm_mode,
  // Command and result bytes
  output logic      [7:0]  command_byte,
  output logic             command_byte_valid,
  input  wire logic [7:0]  result_byte,
  output logic             result_byte_taken,
  // Configure command results
  input  wire logic        buffer_cfg_load,
  input  wire logic        buffer_cfg_enable,
  input  wire logic [3:0]  buffer_cfg_threshold,
  input  wire logic        precomp_track_load,
  input  wire logic [7:0]  precomp_track_value,
  // Engine side of data buffer
  input  wire logic        engine_push,
  input  wire logic [7:0]  engine_push_data,
  input  wire logic        engine_pop,
  output logic      [7:0]  engine_pop_data,
  output logic             engine_buffer_ready,
  output logic             buffer_service_request,
  output logic             transfer_error,
  // Controller control
  output logic      [1:0]  rate_select,
  output logic             fm_rate_illegal,
  output logic      [2:0]  write_shift_select,
  output logic      [7:0]  precomp_start_track,
  output logic             controller_clock_stop,
  output logic             controller_reset
);
  import fdc_host_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    bus_state_type bus;
    logic [11:0]   idx;
    logic          hit;
    logic [31:0]   rdata;
    logic [7:0]    float_mask;
    logic [1:0]    tape_unit_choice;
    logic [1:0]    rate;
    logic [2:0]    precomp;
    logic          low_power;
    logic          soft_reset;
    logic          enhanced;
    logic [7:0]    drive_kind_config;
    logic [7:0]    boot_and_polarity_config;
    logic [7:0]    track;
    logic          buf_enable;
    logic [3:0]    buf_threshold;
    logic          exec_d;
    logic          xfer_err;
    logic [7:0]    cmd_byte;
    logic          cmd_valid;
    logic          result_taken;
  } regs_type;

  regs_type    s_r;
  regs_type    s_nxt;
  logic        accept;
  logic        host_transfer_request;
  logic        transfer_direction;
  logic [7:0]  controller_main_status;
  logic [7:0]  tape_info_value;
  logic        media_kind_bit_high;
  logic        media_kind_bit_low;
  logic [2:0]  steps;
  logic        buf_flush;
  logic        buf_push;
  logic        buf_pop;
  logic        host_push;
  logic        host_pop;
  logic [7:0]  buf_push_data;
  logic [7:0]  buf_pop_data;
  logic [4:0]  buf_count;
  logic        buf_full;
  logic        buf_empty;

  // Maps an aligned word address to a register index; misaligned or high reads miss
  function automatic logic reg_hit(input logic [31:0] a, input logic [11:0] idx);
    return (a[31:14] == 18'h00000) && (a[1:0] == 2'b00) && (a[13:2] == idx);
  endfunction

  // ****************************************
  // Combinational views
  // ****************************************
  assign accept = hsel && htrans[1] && hready;

  assign media_kind_bit_high = media_sense_pin_high ^ s_r.boot_and_polarity_config[POL_HIGH_BIT];
  assign media_kind_bit_low  = media_sense_pin_low ^ s_r.boot_and_polarity_config[POL_LOW_BIT];

  // drive kind pair; boot drive; tape choice
  assign tape_info_value = {media_kind_bit_high,
                            media_kind_bit_low,
                            s_r.drive_kind_config[{last_drive_select, 1'b0} +: 2],
                            s_r.boot_and_polarity_config[1:0],
                            s_r.tape_unit_choice};

  // direction from engine; request from buffer while executing
  assign transfer_direction = engine_direction;
  always_comb begin
    if (s_r.low_power) begin
      host_transfer_request = 1'b0;
    end else if (exec_phase) begin
      host_transfer_request = transfer_direction ? !buf_empty : !buf_full;
    end else begin
      host_transfer_request = engine_request;
    end
  end

  // seek bits; busy bit; polled execution bit
  assign controller_main_status = {host_transfer_request,
                                   transfer_direction,
                                   polled_mode && exec_phase,
                                   command_busy,
                                   drive_seek_active};

  always_comb begin
    if (s_r.precomp == PRECOMP_OFF) begin
      steps = STEPS_NONE;
    end else if (s_r.precomp == PRECOMP_DEFAULT) begin
      steps = (s_r.rate == RATE_1M) ? STEPS_DEFAULT_1M : STEPS_DEFAULT_LOW;
    end else begin
      steps = s_r.precomp;
    end
  end

  assign buf_flush = (exec_phase && !s_r.exec_d) || s_r.soft_reset;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt              = s_r;
    s_nxt.exec_d       = exec_phase;
    s_nxt.xfer_err     = 1'b0;
    s_nxt.cmd_valid    = 1'b0;
    s_nxt.result_taken = 1'b0;
    s_nxt.soft_reset   = 1'b0;
    host_push          = 1'b0;
    host_pop           = 1'b0;

    if (s_r.soft_reset) begin
      s_nxt.low_power     = 1'b0;
      s_nxt.buf_enable    = 1'b0;
      s_nxt.buf_threshold = 4'h0;
    end

    if (buffer_cfg_load) begin
      s_nxt.buf_enable    = buffer_cfg_enable;
      s_nxt.buf_threshold = buffer_cfg_threshold;
    end
    if (precomp_track_load) begin
      s_nxt.track = precomp_track_value;
    end

    // Write data phase: hwdata valid now
    if (s_r.bus == BUS_WRITE && s_r.hit) begin
      if (s_r.idx == IDX_TAPE_INFO) begin
        s_nxt.tape_unit_choice = hwdata[1:0];
      end else if (s_r.idx == IDX_RATE_STATUS) begin
        s_nxt.rate    = hwdata[RATE_LSB +: 2];
        s_nxt.precomp = hwdata[PRECOMP_LSB +: 3];
        if (hwdata[LOW_POWER_BIT]) begin
          s_nxt.low_power = 1'b1;
        end
        s_nxt.soft_reset = hwdata[SOFT_RESET_BIT];
      end else if (s_r.idx == IDX_DATA_PORT) begin
        s_nxt.low_power = 1'b0;
        if (exec_phase && !transfer_direction) begin
          host_push = 1'b1;
          s_nxt.xfer_err = buf_full;
        end else begin
          s_nxt.cmd_byte  = hwdata[7:0];
          s_nxt.cmd_valid = 1'b1;
        end
      end else if (s_r.idx == IDX_CONFIG_RATE) begin
        // rate from the other rate register
        s_nxt.rate = hwdata[RATE_LSB +: 2];
      end else if (s_r.idx == IDX_MODE_CONFIG) begin
        s_nxt.enhanced = hwdata[ENHANCED_BIT];
      end else if (s_r.idx == IDX_DRIVE_KIND) begin
        s_nxt.drive_kind_config = hwdata[7:0];
      end else if (s_r.idx == IDX_BOOT_POLARITY) begin
        s_nxt.boot_and_polarity_config = hwdata[7:0];
      end else if (s_r.idx == IDX_PRECOMP_TRACK) begin
        s_nxt.track = hwdata[7:0];
      end
    end

    // Read capture one cycle after the address, so a write just before is seen
    if (s_r.bus == BUS_RD_WAIT) begin
      s_nxt.rdata      = 32'h0000_0000;
      s_nxt.float_mask = 8'h00;
      if (!s_r.hit) begin
        s_nxt.rdata = 32'h0000_0000;
      end else if (s_r.idx == IDX_TAPE_INFO) begin
        if (s_r.enhanced) begin
          s_nxt.rdata[7:0] = tape_info_value;
        end else begin
          // upper bits undriven in normal mode
          s_nxt.rdata[1:0] = s_r.tape_unit_choice;
          s_nxt.float_mask = FLOAT_NORMAL;
        end
      end else if (s_r.idx == IDX_RATE_STATUS) begin
        s_nxt.rdata[7:0] = controller_main_status;
        s_nxt.low_power  = 1'b0;
      end else if (s_r.idx == IDX_DATA_PORT) begin
        s_nxt.low_power = 1'b0;
        if (exec_phase && transfer_direction) begin
          host_pop         = 1'b1;
          s_nxt.rdata[7:0] = buf_pop_data;
          s_nxt.xfer_err   = buf_empty;
        end else begin
          s_nxt.rdata[7:0]   = result_byte;
          s_nxt.result_taken = 1'b1;
        end
      end else if (s_r.idx == IDX_MODE_CONFIG) begin
        s_nxt.rdata[ENHANCED_BIT] = s_r.enhanced;
      end else if (s_r.idx == IDX_DRIVE_KIND) begin
        s_nxt.rdata[7:0] = s_r.drive_kind_config;
      end else if (s_r.idx == IDX_BOOT_POLARITY) begin
        s_nxt.rdata[7:0] = s_r.boot_and_polarity_config;
      end else if (s_r.idx == IDX_BLOCK_STATUS) begin
        s_nxt.rdata[15:0] = {buf_count[3:0], s_r.buf_threshold, s_r.buf_enable,
                             s_r.low_power, steps, buf_full, s_r.rate};
      end else if (s_r.idx == IDX_PRECOMP_TRACK) begin
        s_nxt.rdata[7:0] = s_r.track;
      end
    end

    // Bus sequencing: reads take one wait state, writes none
    case (s_r.bus)
      BUS_RD_WAIT: begin
        s_nxt.bus = BUS_RD_DONE;
      end
      default: begin
        if (accept) begin
          s_nxt.bus = hwrite ? BUS_WRITE : BUS_RD_WAIT;
          s_nxt.hit = reg_hit(haddr, haddr[13:2]) && (hsize == 3'h2);
          s_nxt.idx = haddr[13:2];
        end else begin
          s_nxt.bus = BUS_IDLE;
          s_nxt.hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r                          <= '0;
      s_r.bus                      <= BUS_IDLE;
      // hard reset gives 250 kb/s, default precomp
      s_r.rate                     <= RATE_RESET;
      s_r.precomp                  <= PRECOMP_RESET;
      s_r.track                    <= TRACK_RESET;
      s_r.buf_enable               <= 1'b0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Data buffer
  // ****************************************
  assign buf_push      = transfer_direction ? engine_push : host_push;
  assign buf_pop       = transfer_direction ? host_pop : engine_pop;
  assign buf_push_data = transfer_direction ? engine_push_data : hwdata[7:0];

  fdc_byte_buffer u_buffer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ce          (ce),
    .flush       (buf_flush),
    .single_byte (!s_r.buf_enable),
    .push        (buf_push),
    .push_data   (buf_push_data),
    .pop         (buf_pop),
    .pop_data    (buf_pop_data),
    .count       (buf_count),
    .full        (buf_full),
    .empty       (buf_empty)
  );

  // Service request once the threshold is reached in either direction
  always_comb begin
    if (!exec_phase) begin
      buffer_service_request = 1'b0;
    end else if (!s_r.buf_enable) begin
      buffer_service_request = transfer_direction ? !buf_empty : buf_empty;
    end else if (transfer_direction) begin
      buffer_service_request = buf_count >= {1'b0, s_r.buf_threshold};
    end else begin
      buffer_service_request = (BUF_FULL - buf_count) >= {1'b0, s_r.buf_threshold};
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hreadyout           = (s_r.bus != BUS_RD_WAIT);
  assign hresp               = 1'b0;
  assign hrdata              = s_r.rdata;
  assign rdata_float         = s_r.float_mask;
  assign command_byte        = s_r.cmd_byte;
  assign command_byte_valid  = s_r.cmd_valid;
  assign result_byte_taken   = s_r.result_taken;
  assign engine_pop_data     = buf_pop_data;
  assign engine_buffer_ready = transfer_direction ? !buf_full : !buf_empty;
  // engine ends command on this pulse
  assign transfer_error      = s_r.xfer_err;
  assign rate_select         = s_r.rate;
  // FM at top rate is illegal
  assign fm_rate_illegal     = fm_mode && (s_r.rate == RATE_1M);
  assign write_shift_select  = steps;
  assign precomp_start_track = s_r.track;
  assign controller_clock_stop = s_r.low_power;
  assign controller_reset      = s_r.soft_reset;

endmodule // floppy_host_register_interface
`default_nettype wire

/* dv/ahb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model (
  // Bus
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
  end
  // ****************
  // Single word transfer
  // ****************
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    // Address phase held until an edge samples hready high
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    // Reads get a moving pattern, not stale write data
    hwdata <= w ? d : ~hwdata;
    // Data phase ends, and read data is taken, at that same edge
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
endmodule // ahb_host_model
`default_nettype wire

/* dv/host_reg_props.sv */
`timescale 1ns/1ps
`default_nettype none
module host_reg_props
  import fdc_host_pkg::*;
(
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Engine and control
  input wire logic [3:0]  drive_seek_active,
  input wire logic        command_busy,
  input wire logic        fm_mode,
  input wire logic [1:0]  rate_select,
  input wire logic        fm_rate_illegal,
  input wire logic [2:0]  write_shift_select,
  input wire logic        controller_clock_stop,
  input wire logic        controller_reset
);
  import fdc_host_pkg::*;
  localparam logic [31:0] A_RS = {18'h0, IDX_RATE_STATUS, 2'b00};
  localparam logic [31:0] A_DP = {18'h0, IDX_DATA_PORT, 2'b00};
  localparam logic [31:0] A_CR = {18'h0, IDX_CONFIG_RATE, 2'b00};
  logic acc;
  logic wr_rs_r;
  logic wr_rate_r;
  assign acc = hsel && htrans[1] && hready && ce;
  // Data phase markers; writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_rs_r   <= 1'b0;
      wr_rate_r <= 1'b0;
    end else if (hready) begin
      wr_rs_r   <= acc && hwrite && haddr == A_RS;
      wr_rate_r <= acc && hwrite && (haddr == A_RS || haddr == A_CR);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_pulse;
    controller_reset ##1 !controller_reset;
  endsequence
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_read_wait: assert property (acc && !hwrite |=> s_rd_wait)
    else $error("read wait state wrong");
  chk_status_bits: assert property (acc && !hwrite && haddr == A_RS
    |=> ##1 hrdata[4:0] == $past({command_busy, drive_seek_active}))
    else $error("status bits wrong");
  chk_rate_follow: assert property (wr_rate_r && hready && !hwdata[7]
    |=> rate_select == $past(hwdata[1:0]))
    else $error("rate not last written");
  chk_shift_off: assert property (wr_rs_r && hready && hwdata[4:2] == PRECOMP_OFF
    |=> write_shift_select == STEPS_NONE)
    else $error("precomp not disabled");
  chk_fm_illegal: assert property (fm_rate_illegal == (fm_mode && rate_select == RATE_1M))
    else $error("fm illegal flag wrong");
  chk_power_enter: assert property (wr_rs_r && hready && hwdata[6] && !hwdata[7]
    |=> controller_clock_stop)
    else $error("low power not entered");
  chk_power_exit: assert property (controller_clock_stop && acc && !hwrite
    && (haddr == A_RS || haddr == A_DP) |=> ##[0:2] !controller_clock_stop)
    else $error("low power not left");
  chk_soft_pulse: assert property (wr_rs_r && hready && hwdata[7] |=> s_pulse)
    else $error("soft reset pulse wrong");
endmodule // host_reg_props
bind floppy_host_register_interface host_reg_props u_props (
  .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .hrdata, .drive_seek_active, .command_busy, .fm_mode, .rate_select,
  .fm_rate_illegal, .write_shift_select, .controller_clock_stop, .controller_reset);
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) \
  begin \
    checks_done++; \
    if ((s) !== (e)) begin \
      error_cnt++; \
      $display("MISMATCH %s expected %h seen %h", n, e, s); \
    end \
  end
module tb;
  import fdc_host_pkg::*;
  typedef struct {logic [11:0] i; logic [7:0] d; logic [1:0] r; logic [2:0] w;} row_type;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, fm_mode, fm_rate_illegal;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans, rate_select, last_drive_select;
  logic [2:0]  hsize, write_shift_select;
  logic [3:0]  drive_seek_active;
  logic [7:0]  rdata_float, command_byte, result_byte, engine_pop_data;
  logic [7:0]  precomp_start_track, precomp_track_value, engine_push_data;
  logic        media_sense_pin_low, media_sense_pin_high, command_busy, exec_phase;
  logic        polled_mode, engine_request, engine_direction, command_byte_valid;
  logic        result_byte_taken, precomp_track_load, engine_push, engine_buffer_ready;
  logic        buffer_service_request, transfer_error, controller_clock_stop, controller_reset;
  int          error_cnt, checks_done, cyc;
  logic        err_seen = 1'b0;
  row_type     rows [7] = '{'{IDX_RATE_STATUS, 8'h02, 2'h2, 3'h3},
                            '{IDX_RATE_STATUS, 8'h03, 2'h3, 3'h1},
                            '{IDX_RATE_STATUS, 8'h1C, 2'h0, 3'h0},
                            '{IDX_RATE_STATUS, 8'h04, 2'h0, 3'h1},
                            '{IDX_RATE_STATUS, 8'h19, 2'h1, 3'h6},
                            '{IDX_CONFIG_RATE, 8'h03, 2'h3, 3'h6},
                            '{IDX_RATE_STATUS, 8'h00, 2'h0, 3'h3}};
  floppy_host_register_interface uut (.*, .hready(hreadyout), .ce(1'b1), .engine_pop(1'b0),
    .buffer_cfg_load(1'b0), .buffer_cfg_enable(1'b0), .buffer_cfg_threshold(4'h0));
  ahb_host_model host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata);
  always #5 hclk = ~hclk;
  // Error pulse lasts one cycle; keep it for a later compare
  always @(posedge hclk) begin
    if (transfer_error === 1'b1) begin
      err_seen <= 1'b1;
    end
  end
  // Hang guard, far above the expected run of about 130 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] ba(input logic [11:0] i);
    return {18'h0, i, 2'b00};
  endfunction
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    host.xfer(1'b1, ba(i), {24'h0, d}, rdv);
    @(negedge hclk);
  endtask
  task automatic rd(input logic [11:0] i);
    host.xfer(1'b0, ba(i), 32'h0, rdv);
    @(negedge hclk);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    hresetn = 1'b0;
    {media_sense_pin_low, command_busy, exec_phase, polled_mode, engine_request} = '0;
    {engine_direction, precomp_track_load, engine_push, drive_seek_active} = '0;
    {last_drive_select, result_byte, precomp_track_value, engine_push_data} = '0;
    {media_sense_pin_high, fm_mode} = 2'b11;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK("rate", 2'h2, rate_select)
    `CHK("shift", 3'h3, write_shift_select)
    `CHK("track", 8'h00, precomp_start_track)
    foreach (rows[k]) begin
      wr(rows[k].i, rows[k].d);
      `CHK("rate", rows[k].r, rate_select)
      `CHK("shift", rows[k].w, write_shift_select)
    end
    wr(IDX_TAPE_INFO, 8'h03);
    rd(IDX_TAPE_INFO);
    `CHK("tape", 8'h03, rdv[7:0])
    `CHK("float", 8'hFC, rdata_float)
    wr(IDX_MODE_CONFIG, 8'h01);
    wr(IDX_DRIVE_KIND, 8'hE4);
    wr(IDX_BOOT_POLARITY, 8'h0E);
    for (int d = 0; d < 4; d++) begin
      @(posedge hclk);
      last_drive_select <= d[1:0];
      rd(IDX_TAPE_INFO);
      `CHK("tape", {2'b01, d[1:0], 4'hB}, rdv[7:0])
    end
    `CHK("float", 8'h00, rdata_float)
    @(posedge hclk);
    media_sense_pin_low <= 1'b1;
    wr(IDX_RATE_STATUS, 8'h80);
    rd(IDX_TAPE_INFO);
    `CHK("tape", 8'h3B, rdv[7:0])
    `CHK("rate", 2'h0, rate_select)
    wr(IDX_RATE_STATUS, 8'h40);
    `CHK("stop", 1'b1, controller_clock_stop)
    rd(IDX_RATE_STATUS);
    `CHK("stop", 1'b0, controller_clock_stop)
    @(posedge hclk);
    drive_seek_active <= 4'h5;
    {command_busy, exec_phase, polled_mode, engine_request, engine_direction} <= 5'h17;
    rd(IDX_RATE_STATUS);
    `CHK("status", 8'hD5, rdv[7:0])
    @(posedge hclk);
    exec_phase <= 1'b1;
    rd(IDX_RATE_STATUS);
    `CHK("status", 6'h35, rdv[5:0])
    @(posedge hclk);
    engine_push <= 1'b1;
    engine_push_data <= 8'h33;
    @(posedge hclk);
    engine_push <= 1'b0;
    rd(IDX_BLOCK_STATUS);
    `CHK("count", 4'h1, rdv[15:12])
    `CHK("service", 1'b1, buffer_service_request)
    rd(IDX_RATE_STATUS);
    rd(IDX_DATA_PORT);
    `CHK("data", 8'h33, rdv[7:0])
    @(posedge hclk);
    engine_push <= 1'b1;
    @(posedge hclk);
    engine_push <= 1'b0;
    exec_phase <= 1'b0;
    @(posedge hclk);
    exec_phase <= 1'b1;
    rd(IDX_BLOCK_STATUS);
    `CHK("count", 4'h0, rdv[15:12])
    `CHK("underrun", 1'b0, err_seen)
    rd(IDX_DATA_PORT);
    `CHK("underrun", 1'b1, err_seen)
    @(posedge hclk);
    {command_busy, exec_phase, polled_mode, engine_request, engine_direction} <= 5'h16;
    wr(IDX_DATA_PORT, 8'h0A);
    `CHK("command", 8'h0A, command_byte)
    @(posedge hclk);
    result_byte <= 8'h5A;
    engine_direction <= 1'b1;
    rd(IDX_DATA_PORT);
    `CHK("result", 8'h5A, rdv[7:0])
    @(posedge hclk);
    precomp_track_load <= 1'b1;
    precomp_track_value <= 8'h05;
    @(posedge hclk);
    precomp_track_load <= 1'b0;
    @(negedge hclk);
    `CHK("track", 8'h05, precomp_start_track)
    rd(12'h040);
    `CHK("unmapped", 32'h0, rdv)
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK("rate", 2'h2, rate_select)
    rd(IDX_BLOCK_STATUS);
    `CHK("enable", 1'b0, rdv[7])
    end_sim();
  end
endmodule // tb
`default_nettype wire
